// File: frc_consts.svh
/*
  Constants for the fixed reference control block: control bit positions,
  reset values and the stabilization timing.
  Assumes inclusion by bare name from files that use these macros.
*/
`ifndef FRC_CONSTS_SVH
`define FRC_CONSTS_SVH
// ==========================================================================
// Control register layout
`define FRC_CTRL_W 8
`define FRC_CTRL_RESET 8'h00
`define FRC_BIT_ENABLE 7
`define FRC_BIT_READY 6
`define FRC_BIT_BUFEN 5
`define FRC_SEL_LSB 0
`define FRC_SEL_MSB 1
`define FRC_SEL_OPAMP 2'h1
`define FRC_SEL_FIXED 2'h2
`define FRC_SEL_DAC 2'h3
// ==========================================================================
// Stabilization timing: time in ns, clock period in ns.
`define FRC_STAB_NS 25000
`define FRC_CLK_NS 50
`define FRC_STAB_CYCLES ((`FRC_STAB_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)
`define FRC_CNT_W 16
`endif

// File: frc_pkg.sv
/*
  Types for the fixed reference control block.
  Assumes frc_consts.svh is on the include path.
*/
`include "frc_consts.svh"
package frc_pkg;
  typedef enum logic [1:0] {FRC_OFF, FRC_SETTLE, FRC_READY} frc_stab_t;
  typedef logic [`FRC_CTRL_W-1:0] frc_ctrl_t;
endpackage

// File: frc_stab_timer.sv
/*
  Stabilization timer: raises ready a fixed count of cycles after enable.
  Assumes the enable is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.svh"
module frc_stab_timer #(
  parameter logic [`FRC_CNT_W-1:0] STAB_CYCLES = `FRC_CNT_W'(`FRC_STAB_CYCLES)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic refOn,
  output logic ready
);
  typedef struct packed {
    frc_pkg::frc_stab_t st;
    logic [`FRC_CNT_W-1:0] cnt;
    logic ready;
  } frc_tmr_state_t;

  frc_tmr_state_t s;
  frc_tmr_state_t next_s;

  // ========================================================================
  // Settle counter; dropping the enable restarts the wait from zero.
  always_comb begin
    next_s = s;
    case (s.st)
      frc_pkg::FRC_OFF: begin
        next_s.cnt = '0;
        next_s.ready = 1'b0;
        if (refOn) begin
          next_s.st = frc_pkg::FRC_SETTLE;
        end
      end
      frc_pkg::FRC_SETTLE: begin
        next_s.cnt = s.cnt + `FRC_CNT_W'(1);
        if (s.cnt + `FRC_CNT_W'(1) >= STAB_CYCLES) begin
          next_s.st = frc_pkg::FRC_READY;
          next_s.ready = 1'b1;
        end
      end
      frc_pkg::FRC_READY: begin
        next_s.ready = 1'b1;
      end
      default: begin
        next_s.st = frc_pkg::FRC_OFF;
      end
    endcase
    if (!refOn) begin
      next_s.st = frc_pkg::FRC_OFF;
      next_s.cnt = '0;
      next_s.ready = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: frc_pkg::FRC_OFF, cnt: '0, ready: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign ready = s.ready;

  AST_READY_OFF: assert property (@(posedge clk) disable iff (!rstn)
    !refOn |=> !ready)
    else $error("ready stayed high with reference off");
endmodule
`default_nettype wire

// File: frc_fixed_reference.sv
/*
  Fixed reference control: enable, source routing to ADC, comparators,
  shunt regulator and output pin buffer, pin digital override, ready flag.
  Assumes a synchronous write strobe with data; sleep wake leaves state alone.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frc_consts.svh"
module frc_fixed_reference #(
  parameter bit ALWAYS_ON = 1'b0,
  parameter logic [`FRC_CNT_W-1:0] STAB_CYCLES = `FRC_CNT_W'(`FRC_STAB_CYCLES)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ctrlWrite,
  input wire logic [`FRC_CTRL_W-1:0] ctrlWdata,
  input wire logic sleepWake,
  input wire logic pinDigitalIn,
  input wire logic pinDigitalOutEn,
  input wire logic adcSelRef,
  input wire logic cmp1SelRef,
  input wire logic cmp2SelRef,
  input wire logic shuntSelRef,
  output logic [`FRC_CTRL_W-1:0] ctrlRdata,
  output logic refEnabled,
  output logic refStableFlag,
  output logic adcRefRoute,
  output logic comparator1PosInput,
  output logic comparator2PosInput,
  output logic shuntRefRoute,
  output logic bufferOn,
  output logic [1:0] bufferSourceSelect,
  output logic refOutputPin,
  output logic pinDigitalOverride,
  output logic pinReadValue,
  output logic pinDigitalOutEnGated
);
  typedef struct packed {
    frc_pkg::frc_ctrl_t ctrl;
    logic refEnabled;
    logic stable;
    logic adc;
    logic cmp1;
    logic cmp2;
    logic shunt;
    logic bufOn;
    logic [1:0] sel;
    logic pinRef;
    logic override;
    logic pinRead;
    logic doutEn;
  } frc_state_t;

  frc_state_t s;
  frc_state_t next_s;
  logic ready;
  logic refOnNow;

  // ========================================================================
  // Helpers
  function automatic logic frc_sel_valid(input logic [1:0] sel);
    frc_sel_valid = (sel == `FRC_SEL_OPAMP) || (sel == `FRC_SEL_FIXED) ||
      (sel == `FRC_SEL_DAC);
  endfunction

  assign refOnNow = ALWAYS_ON | s.ctrl[`FRC_BIT_ENABLE];

  frc_stab_timer #(.STAB_CYCLES(STAB_CYCLES)) u_timer (
    .clk(clk),
    .rstn(rstn),
    .refOn(refOnNow),
    .ready(ready)
  );

  // ========================================================================
  // Control register and derived routing
  always_comb begin
    logic [`FRC_CTRL_W-1:0] ctrlNew;
    logic en;
    logic pinOn;
    logic readyNow;
    ctrlNew = s.ctrl;
    en = 1'b0;
    pinOn = 1'b0;
    readyNow = 1'b0;
    next_s = s;
    // A write during a wake strobe is dropped, so the enable and bits 5:0 hold; the ready bit still tracks the timer.
    if (ctrlWrite && !sleepWake) begin
      ctrlNew = ctrlWdata;
    end
    en = ALWAYS_ON | ctrlNew[`FRC_BIT_ENABLE];
    // The timer sees an enable change one edge late, so its ready is masked
    // until the reference has been on for a full cycle; otherwise a quick
    // off-on toggle or a disable would show a stale ready for a cycle.
    readyNow = ready && en && s.refEnabled;
    ctrlNew[`FRC_BIT_READY] = readyNow;
    next_s.ctrl = ctrlNew;
    pinOn = ctrlNew[`FRC_BIT_BUFEN] &&
      frc_sel_valid(ctrlNew[`FRC_SEL_MSB:`FRC_SEL_LSB]);
    next_s.refEnabled = en;
    next_s.stable = readyNow;
    next_s.adc = en & adcSelRef;
    next_s.cmp1 = en & cmp1SelRef;
    next_s.cmp2 = en & cmp2SelRef;
    next_s.shunt = en & shuntSelRef;
    next_s.bufOn = pinOn;
    next_s.sel = pinOn ? ctrlNew[`FRC_SEL_MSB:`FRC_SEL_LSB] : 2'h0;
    // The fixed source is only meaningful while the reference itself is on.
    next_s.pinRef = pinOn &&
      (ctrlNew[`FRC_SEL_MSB:`FRC_SEL_LSB] != `FRC_SEL_FIXED || en);
    next_s.override = pinOn;
    next_s.pinRead = pinOn ? 1'b0 : pinDigitalIn;
    next_s.doutEn = pinOn ? 1'b0 : pinDigitalOutEn;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ctrlRdata = s.ctrl;
  assign refEnabled = s.refEnabled;
  assign refStableFlag = s.stable;
  assign adcRefRoute = s.adc;
  assign comparator1PosInput = s.cmp1;
  assign comparator2PosInput = s.cmp2;
  assign shuntRefRoute = s.shunt;
  assign bufferOn = s.bufOn;
  assign bufferSourceSelect = s.sel;
  assign refOutputPin = s.pinRef;
  assign pinDigitalOverride = s.override;
  assign pinReadValue = s.pinRead;
  assign pinDigitalOutEnGated = s.doutEn;

  // ========================================================================
  // Checks: enable and routing
  AST_ROUTE_NEEDS_EN: assert property (@(posedge clk) disable iff (!rstn)
    adcRefRoute |-> refEnabled)
    else $error("ADC routed with reference off");
  AST_CMP1_NEEDS_EN: assert property (@(posedge clk) disable iff (!rstn)
    comparator1PosInput |-> refEnabled)
    else $error("comparator 1 routed with reference off");
  AST_CMP2_NEEDS_EN: assert property (@(posedge clk) disable iff (!rstn)
    comparator2PosInput |-> refEnabled)
    else $error("comparator 2 routed with reference off");
  AST_SHUNT_NEEDS_EN: assert property (@(posedge clk) disable iff (!rstn)
    shuntRefRoute |-> refEnabled)
    else $error("shunt routed with reference off");
  // A route takes its consumer's select at the same edge that loads the enable.
  AST_ADC_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
    adcRefRoute == (refEnabled && $past(adcSelRef)))
    else $error("ADC route does not follow its select");
  AST_CMP1_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
    comparator1PosInput == (refEnabled && $past(cmp1SelRef)))
    else $error("comparator 1 route does not follow its select");
  AST_CMP2_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
    comparator2PosInput == (refEnabled && $past(cmp2SelRef)))
    else $error("comparator 2 route does not follow its select");
  AST_SHUNT_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
    shuntRefRoute == (refEnabled && $past(shuntSelRef)))
    else $error("shunt route does not follow its select");
  AST_SOFT_EN: assert property (@(posedge clk) disable iff (!rstn)
    !ALWAYS_ON |-> (refEnabled == ctrlRdata[`FRC_BIT_ENABLE]))
    else $error("enable mismatch");
  AST_ALWAYS_ON: assert property (@(posedge clk) disable iff (!rstn)
    ALWAYS_ON |=> refEnabled)
    else $error("high-voltage variant reference off");

  // ========================================================================
  // Checks: output pin
  AST_PIN_NEEDS_BOTH: assert property (@(posedge clk) disable iff (!rstn)
    refOutputPin |-> (ctrlRdata[`FRC_BIT_BUFEN] && bufferSourceSelect != 2'h0))
    else $error("pin driven without select and enable");
  AST_FIXED_NEEDS_REF: assert property (@(posedge clk) disable iff (!rstn)
    (refOutputPin && bufferSourceSelect == `FRC_SEL_FIXED) |-> refEnabled)
    else $error("fixed source on pin with reference off");
  AST_SEL_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
    bufferOn |-> (bufferSourceSelect == ctrlRdata[`FRC_SEL_MSB:`FRC_SEL_LSB]))
    else $error("buffer select mismatch");
  AST_SEL_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    !bufferOn |-> (bufferSourceSelect == 2'h0))
    else $error("buffer select shown with buffer off");
  AST_OVERRIDE: assert property (@(posedge clk) disable iff (!rstn)
    pinDigitalOverride |-> !pinDigitalOutEnGated)
    else $error("digital out left on");
  AST_OVERRIDE_BUF: assert property (@(posedge clk) disable iff (!rstn)
    pinDigitalOverride == bufferOn)
    else $error("override does not track the buffer");
  // The pass-through checks skip the first edge after reset, where the pin
  // registers still hold their cleared values rather than last cycle's inputs.
  AST_DOUT_PASS: assert property (@(posedge clk) disable iff (!rstn)
    ($past(rstn) && !pinDigitalOverride) |-> (pinDigitalOutEnGated == $past(pinDigitalOutEn)))
    else $error("digital out enable not passed through");
  AST_READ_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    pinDigitalOverride |-> !pinReadValue)
    else $error("pin read not zero");
  AST_PIN_PASS: assert property (@(posedge clk) disable iff (!rstn)
    ($past(rstn) && !pinDigitalOverride) |-> (pinReadValue == $past(pinDigitalIn)))
    else $error("pin read not passed through");

  // ========================================================================
  // Checks: ready, wake and reset
  AST_READY_BIT: assert property (@(posedge clk) disable iff (!rstn)
    ctrlRdata[`FRC_BIT_READY] == refStableFlag)
    else $error("ready bit and ready flag differ");
  AST_READY_DELAY: assert property (@(posedge clk) disable iff (!rstn)
    $rose(refEnabled) |-> (!refStableFlag)[*2])
    else $error("ready too early");
  AST_WAKE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    sleepWake |=> (ctrlRdata[`FRC_BIT_ENABLE] == $past(ctrlRdata[`FRC_BIT_ENABLE]) &&
    ctrlRdata[`FRC_BIT_BUFEN:0] == $past(ctrlRdata[`FRC_BIT_BUFEN:0])))
    else $error("wake changed control");
  AST_RESET_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> (ctrlRdata == `FRC_CTRL_RESET))
    else $error("control not cleared by reset");
  AST_RESET_PIN: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> (!refOutputPin && !bufferOn))
    else $error("pin output survived reset");
  AST_READY_LOW: assert property (@(posedge clk) disable iff (!rstn)
    !refEnabled |-> ##1 (!refStableFlag)[*2])
    else $error("ready high while off");
  AST_STABLE_NEEDS_EN: assert property (@(posedge clk) disable iff (!rstn)
    refStableFlag |-> refEnabled)
    else $error("ready shown with reference off");
endmodule
`default_nettype wire

// File: frc_far_side.sv
/*
  Far-side model: the reference consumers and the digital path of the pin.
  Assumes the bench decides whether the consumers select the reference.
*/
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Consumers and pin
module frc_far_side (
  input wire logic selAll,
  output logic adcSelRef,
  output logic cmp1SelRef,
  output logic cmp2SelRef,
  output logic shuntSelRef,
  output logic pinDigitalIn,
  output logic pinDigitalOutEn
);
  assign adcSelRef = selAll;
  assign cmp1SelRef = selAll;
  assign cmp2SelRef = selAll;
  assign shuntSelRef = selAll;
  // The pin's digital path follows the select line, so the bench can see it pass
  // through while the buffer is off and forced low while the buffer is on.
  assign pinDigitalIn = selAll;
  assign pinDigitalOutEn = selAll;
endmodule
`default_nettype wire

// File: frc_fixed_reference_test.sv
/*
  Self-checking bench for the fixed reference control block.
  Assumes the design files and frc_far_side are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module frc_fixed_reference_test;
  logic clk, rstn, ctrlWrite, sleepWake, selAll;
  logic [7:0] ctrlWdata, ctrlRdata;
  logic adcSel, c1Sel, c2Sel, shSel, pinIn, pinOe;
  logic refEnabled, refStableFlag, adcRefRoute, cmp1, cmp2, shuntRefRoute;
  logic bufferOn, refOutputPin, pinDigitalOverride, pinReadValue, pinOeGated, hvOn;
  logic [1:0] bufferSourceSelect;
  int err_total, compares;
  frc_far_side i_frc_far_side (.selAll(selAll), .adcSelRef(adcSel), .cmp1SelRef(c1Sel),
    .cmp2SelRef(c2Sel), .shuntSelRef(shSel), .pinDigitalIn(pinIn), .pinDigitalOutEn(pinOe));
  frc_fixed_reference #(.ALWAYS_ON(1'b0), .STAB_CYCLES(16'h0004)) i_frc_fixed_reference (
    .clk(clk), .rstn(rstn), .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata),
    .sleepWake(sleepWake), .pinDigitalIn(pinIn), .pinDigitalOutEn(pinOe),
    .adcSelRef(adcSel), .cmp1SelRef(c1Sel), .cmp2SelRef(c2Sel), .shuntSelRef(shSel),
    .ctrlRdata(ctrlRdata), .refEnabled(refEnabled), .refStableFlag(refStableFlag),
    .adcRefRoute(adcRefRoute), .comparator1PosInput(cmp1), .comparator2PosInput(cmp2),
    .shuntRefRoute(shuntRefRoute), .bufferOn(bufferOn), .bufferSourceSelect(bufferSourceSelect),
    .refOutputPin(refOutputPin), .pinDigitalOverride(pinDigitalOverride),
    .pinReadValue(pinReadValue), .pinDigitalOutEnGated(pinOeGated));
  // The high-voltage variant shares every input; only its enable is watched.
  frc_fixed_reference #(.ALWAYS_ON(1'b1), .STAB_CYCLES(16'h0004)) i_frc_fixed_reference_hv (
    .clk(clk), .rstn(rstn), .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata),
    .sleepWake(sleepWake), .pinDigitalIn(pinIn), .pinDigitalOutEn(pinOe),
    .adcSelRef(adcSel), .cmp1SelRef(c1Sel), .cmp2SelRef(c2Sel), .shuntSelRef(shSel),
    .ctrlRdata(), .refEnabled(hvOn), .refStableFlag(), .adcRefRoute(), .comparator1PosInput(),
    .comparator2PosInput(), .shuntRefRoute(), .bufferOn(), .bufferSourceSelect(),
    .refOutputPin(), .pinDigitalOverride(), .pinReadValue(), .pinDigitalOutEnGated());
  // ==========================================================================
  // Tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic wake);
    @(posedge clk);
    #2 ctrlWrite = 1'b1;
    ctrlWdata = d;
    sleepWake = wake;
    @(posedge clk);
    #2 ctrlWrite = 1'b0;
    sleepWake = 1'b0;
  endtask
  task automatic end_sim;
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #200000 err_total++;
    end_sim();
  end
  // ==========================================================================
  // Tests
  initial begin
    err_total = 0;
    compares = 0;
    rstn = 1'b0;
    ctrlWrite = 1'b0;
    ctrlWdata = 8'h00;
    sleepWake = 1'b0;
    selAll = 1'b1;
    repeat (8) @(posedge clk);
    #2 rstn = 1'b1;
    chk("ctrl at reset", ctrlRdata, 8'h00);
    chk("ready at reset", refStableFlag, 1'b0);
    @(posedge clk);
    #2 chk("hv enable", hvOn, 1'b1);
    wr(8'h40, 1'b0);
    chk("ready write ignored", ctrlRdata, 8'h00);
    chk("hv enable kept", hvOn, 1'b1);
    wr(8'h80, 1'b0);
    chk("enable", refEnabled, 1'b1);
    chk("ready early", refStableFlag, 1'b0);
    chk("routes", {adcRefRoute, cmp1, cmp2, shuntRefRoute}, 8'h0f);
    for (int i = 0; i < 20 && refStableFlag !== 1'b1; i++) @(posedge clk) #2;
    chk("ready", refStableFlag, 1'b1);
    chk("ctrl ready bit", ctrlRdata, 8'hc0);
    selAll = 1'b0;
    @(posedge clk);
    #2 chk("routes unselected", {adcRefRoute, cmp1, cmp2, shuntRefRoute}, 8'h00);
    chk("pin read pass", pinReadValue, 1'b0);
    chk("pin out enable pass", pinOeGated, 1'b0);
    selAll = 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(8'h80 | (s[2] ? 8'h20 : 8'h00) | 8'(s[1:0]), 1'b0);
      chk("buffer on", bufferOn, s[2] && s[1:0] != 2'h0);
      chk("buffer source", bufferSourceSelect, s[2] ? s[1:0] : 2'h0);
      chk("pin output", refOutputPin, s[2] && s[1:0] != 2'h0);
      chk("override", pinDigitalOverride, s[2] && s[1:0] != 2'h0);
      chk("pin out enable", pinOeGated, !(s[2] && s[1:0] != 2'h0));
      chk("pin read", pinReadValue, !(s[2] && s[1:0] != 2'h0));
    end
    wr(8'h00, 1'b1);
    chk("ctrl after wake", ctrlRdata, 8'he3);
    // Software turns the reference off ahead of sleep.
    wr(8'h00, 1'b0);
    chk("disable", refEnabled, 1'b0);
    chk("routes off", {adcRefRoute, cmp1, cmp2, shuntRefRoute}, 8'h00);
    repeat (2) @(posedge clk);
    #2 chk("ready off", refStableFlag, 1'b0);
    wr(8'h22, 1'b0);
    chk("pin needs reference", refOutputPin, 1'b0);
    chk("buffer without reference", bufferOn, 1'b1);
    wr(8'ha2, 1'b0);
    chk("pin before reset", refOutputPin, 1'b1);
    rstn = 1'b0;
    #2 chk("ctrl mid reset", ctrlRdata, 8'h00);
    chk("pin mid reset", refOutputPin, 1'b0);
    chk("enable mid reset", refEnabled, 1'b0);
    @(posedge clk);
    #2 rstn = 1'b1;
    @(posedge clk);
    #2 chk("ctrl after reset", ctrlRdata, 8'h00);
    chk("hv after reset", hvOn, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
